// File: hw/scan_seq.sv
/*
 Triggered scan sequencer: stepping and whole-list scans started by front-panel
 or external triggers, or by threshold events on a monitor channel.
 Assumes an APB master, a measurement engine that returns meas_done after each
 meas_strobe, and threshold flags already computed for the monitor channel.
*/
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [RULE_01] Enabling stepping closes the first list channel before any trigger.
// [RULE_02] Each stepping trigger measures once, then moves to the next channel.
// [RULE_03] After the last entry is measured the first channel closes again.
// [RULE_04] Reading count sets measurements; list wraps when count exceeds length.
// [RULE_05] Counted sequence done: stay enabled, idle until step request or trigger.
// [RULE_06] Whole-list enable closes first channel; each trigger runs one full pass.
// [RULE_07] Reading count sets passes, each needs its trigger; first channel recloses.
// [RULE_08] After final pass stay enabled idle until list request or trigger.
// [RULE_09] Entering external-trigger mode lights trigger indicator and blanks display.
// [RULE_10] Halt disables the scan; external mode leaves only by its own toggle.
// [RULE_11] Any enabled threshold event on the monitor channel starts a scan.
// [RULE_12] Over-range counts as positive for threshold evaluation.
// [RULE_13] Monitor scans use the most recently enabled scan mode.
// [RULE_14] Immediate option and four source enables held; immediate blocks thresholds.
// [RULE_15] Limit checking enabled lights both high and low limit indicators.
// [RULE_16] Visiting the monitor channel shows the reading that caused the trigger.
// [RULE_17] Threshold still present at scan end retriggers at once.
// [RULE_18] Manual step or list request also starts a scan in monitor mode.
// [RULE_19] Monitor toggle off stops monitor scans and indicator; limits stay separate.
// [RULE_20] Host sets the monitor channel count with its dedicated command.
// [RULE_21] Monitor channel count accepted only from 2 to 55000.
// [RULE_22] External trigger synchronised and edge-detected to one event.
module scan_seq
	import scan_seq_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               trig_key,
	input  wire logic               ext_trig_in,
	input  wire logic               meas_done,
	input  wire logic [`CNT_W-1:0]  meas_reading,
	input  wire logic               reading_sign_neg,
	input  wire logic               over_range_indication,
	input  wire thresh_t            thresh_hit,
	output logic                    meas_strobe,
	output logic [`CH_W-1:0]        closed_ch,
	output logic                    channel_closed,
	output logic                    step_indicator,
	output logic                    list_indicator,
	output logic                    trig_indicator,
	output logic                    display_blank,
	output logic                    monitor_indicator,
	output logic                    high_limit_indicator,
	output logic                    low_limit_indicator,
	output logic [`CNT_W-1:0]       display_value
);
	seq_regs_t r_ff;
	seq_regs_t nxt_r;

	// Any enabled threshold event
	function automatic logic any_event(input thresh_t hit, input thresh_t en);
		any_event = |(hit & en);
	endfunction : any_event

	logic wr_acc;
	logic trig_evt;
	logic mon_evt;
	logic at_last;
	thresh_t hit_eff;
	assign wr_acc = psel & penable & pwrite;
	assign at_last = (r_ff.ch == r_ff.list_len - 6'h01);

	always_comb begin
		// [RULE_12] Over-range taken as positive
		hit_eff = thresh_hit;
		if (over_range_indication) begin
			hit_eff.low_one = 1'b0;
			hit_eff.low_two = 1'b0;
		end
	end

	// Next-state of the whole block
	always_comb begin
		nxt_r = r_ff;
		nxt_r.pready = 1'b0;
		nxt_r.meas_strobe = 1'b0;
		// [RULE_22] Two-stage sync, edge on third
		nxt_r.trig_s1 = ext_trig_in;
		nxt_r.trig_s2 = r_ff.trig_s1;
		nxt_r.trig_s3 = r_ff.trig_s2;
		trig_evt = (r_ff.trig_s2 & ~r_ff.trig_s3) | trig_key;
		// [RULE_11] Enabled event, [RULE_14] immediate blocks it, [RULE_19] needs monitor on
		mon_evt = r_ff.mon_on & ~r_ff.imm_start & any_event(hit_eff, r_ff.src_en)
			& (r_ff.state == ST_IDLE || r_ff.state == ST_ARM);

		// APB registers
		if (psel & ~penable)
			nxt_r.pready = 1'b1;
		// Read data loaded in setup so it stands with pready
		if (psel & ~penable & ~pwrite) begin
			case (paddr)
			`ADDR_CTRL:   nxt_r.prdata = {10'h000, r_ff.mon_ch, 3'h0, r_ff.limit_en, r_ff.src_en,
					2'h0, r_ff.imm_start, r_ff.mon_on, r_ff.ext_mode, 3'h0};
			`ADDR_LIST:   nxt_r.prdata = {26'h0000000, r_ff.list_len};
			`ADDR_COUNT:  nxt_r.prdata = {16'h0000, r_ff.read_cnt};
			`ADDR_MONCNT: nxt_r.prdata = {16'h0000, r_ff.mon_cnt};
			`ADDR_STATUS: nxt_r.prdata = {7'h00, r_ff.done_cnt, r_ff.ch, r_ff.list_mode, r_ff.state};
			default:      nxt_r.prdata = 32'h00000000;
			endcase
		end
		if (wr_acc & r_ff.pready) begin
			nxt_r.pready = 1'b0;
			case (paddr)
			`ADDR_CTRL: begin
				nxt_r.imm_start = pwdata[`CTRL_IMM];
				nxt_r.src_en = pwdata[`CTRL_SRC_LO+3:`CTRL_SRC_LO];
				nxt_r.limit_en = pwdata[`CTRL_LIMIT_EN];
				nxt_r.mon_ch = pwdata[`CTRL_MON_CH_LO+5:`CTRL_MON_CH_LO];
				// [RULE_09] Entering external mode blanks display
				if (pwdata[`CTRL_EXT_TOG]) begin
					nxt_r.ext_mode = ~r_ff.ext_mode;
					nxt_r.blank = ~r_ff.ext_mode;
				end
				// [RULE_19] Monitor toggle
				if (pwdata[`CTRL_MON_TOG])
					nxt_r.mon_on = ~r_ff.mon_on;
				// [RULE_10] Halt disables scan only
				if (pwdata[`CTRL_HALT]) begin
					nxt_r.state = ST_OFF;
				end else if (pwdata[`CTRL_STEP_REQ] | pwdata[`CTRL_LIST_REQ]) begin
					// [RULE_13] Latest request sets the mode
					nxt_r.list_mode = pwdata[`CTRL_LIST_REQ];
					if (r_ff.state == ST_OFF) begin
						// [RULE_01] First channel closes on enable
						nxt_r.ch = '0;
						nxt_r.done_cnt = '0;
						nxt_r.state = (r_ff.ext_mode ? ST_ARM : ST_MEAS);
					end else if (r_ff.state == ST_IDLE || r_ff.state == ST_ARM) begin
						// [RULE_05] Request leaves idle, [RULE_18] also in monitor
						nxt_r.done_cnt = (r_ff.state == ST_IDLE) ? '0 : r_ff.done_cnt;
						nxt_r.state = ST_MEAS;
						nxt_r.meas_strobe = 1'b1;
					end
				end
			end
			`ADDR_LIST:  if (pwdata[5:0] != 6'h00) nxt_r.list_len = pwdata[5:0];
			`ADDR_COUNT: if (pwdata[15:0] != 16'h0000) nxt_r.read_cnt = pwdata[15:0];
			// [RULE_21] Range check on monitor count
			`ADDR_MONCNT: if (pwdata[31:16] == 16'h0000 && pwdata[15:0] >= `MON_CNT_MIN
					&& pwdata[15:0] <= `MON_CNT_MAX) nxt_r.mon_cnt = pwdata[15:0];
			default: ;
			endcase
		end

		// Sequencer
		case (r_ff.state)
		ST_OFF: ;
		ST_ARM, ST_IDLE: begin
			// [RULE_05] [RULE_08] Trigger or monitor event leaves idle
			if (trig_evt | mon_evt) begin
				if (r_ff.state == ST_IDLE)
					nxt_r.done_cnt = '0;
				if (mon_evt) begin
					nxt_r.held_reading = meas_reading;
					nxt_r.hold_valid = 1'b1;
				end
				nxt_r.blank = 1'b0;
				nxt_r.state = ST_MEAS;
				nxt_r.meas_strobe = 1'b1;
			end
		end
		ST_MEAS: begin
			if (r_ff.meas_strobe == 1'b0 && meas_done) begin
				// [RULE_02] Open and close next; [RULE_03] wrap to first
				nxt_r.ch = at_last ? '0 : r_ff.ch + 6'h01;
				if (!r_ff.list_mode || at_last) begin
					// [RULE_04] [RULE_07] Count measurements or passes
					nxt_r.done_cnt = r_ff.done_cnt + 16'h0001;
					if (r_ff.done_cnt + 16'h0001 >= r_ff.read_cnt) begin
						nxt_r.state = ST_IDLE;
						nxt_r.hold_valid = 1'b0;
						// [RULE_17] Event persists: go again
						if (r_ff.mon_on & ~r_ff.imm_start & any_event(hit_eff, r_ff.src_en)) begin
							// New scan holds its own triggering reading
							nxt_r.held_reading = meas_reading;
							nxt_r.hold_valid = 1'b1;
							nxt_r.done_cnt = '0;
							nxt_r.state = ST_MEAS;
							nxt_r.meas_strobe = 1'b1;
						end
					end else
						nxt_r.state = ST_ARM;
				end else
					// [RULE_06] Whole pass runs without further triggers
					nxt_r.meas_strobe = 1'b1;
			end
		end
		default: nxt_r.state = ST_OFF;
		endcase

		// [RULE_16] Registered display: held reading on monitor channel
		// One cycle behind the engine, so the port comes from a flip-flop
		if (r_ff.hold_valid && r_ff.ch == r_ff.mon_ch)
			nxt_r.disp = r_ff.held_reading;
		else
			nxt_r.disp = meas_reading;
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r_ff <= '0;
			r_ff.list_len <= `LIST_LEN_RST;
			r_ff.read_cnt <= `READ_CNT_RST;
			r_ff.mon_cnt <= `MON_CNT_RST;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Ports from flip-flops; pslverr tied low, enable and mode lamps decoded from state
	assign prdata = r_ff.prdata;
	assign pready = r_ff.pready;
	assign pslverr = 1'b0;
	assign meas_strobe = r_ff.meas_strobe;
	assign closed_ch = r_ff.ch;
	assign channel_closed = (r_ff.state != ST_OFF);
	assign step_indicator = r_ff.state[0] | r_ff.state[1] ? ~r_ff.list_mode : 1'b0;
	assign list_indicator = r_ff.state[0] | r_ff.state[1] ? r_ff.list_mode : 1'b0;
	// [RULE_09] Trigger indicator follows mode
	assign trig_indicator = r_ff.ext_mode;
	assign display_blank = r_ff.blank;
	assign monitor_indicator = r_ff.mon_on;
	// [RULE_15] Both limit lamps
	assign high_limit_indicator = r_ff.limit_en;
	assign low_limit_indicator = r_ff.limit_en;
	// [RULE_16] Triggering reading on monitor channel
	assign display_value = r_ff.disp;
endmodule : scan_seq
`default_nettype wire

// File: hw/scan_seq_defines.svh
/*
 Widths, count limits, reset values, addresses and control bits for the triggered scan sequencer.
 Assumes inclusion by bare name from the package; the design file uses it without an include.
*/
`ifndef SCAN_SEQ_DEFINES_SVH
`define SCAN_SEQ_DEFINES_SVH
`define CH_W            6
`define CNT_W           16
`define MON_CNT_MIN     16'h0002
`define MON_CNT_MAX     16'hd6d8
`define MON_CNT_RST     16'h0002
`define LIST_LEN_RST    6'h01
`define READ_CNT_RST    16'h0001
`define ADDR_CTRL       12'h000
`define ADDR_LIST       12'h004
`define ADDR_COUNT      12'h008
`define ADDR_MONCNT     12'h00c
`define ADDR_STATUS     12'h010
`define CTRL_STEP_REQ   0
`define CTRL_LIST_REQ   1
`define CTRL_HALT       2
`define CTRL_EXT_TOG    3
`define CTRL_MON_TOG    4
`define CTRL_IMM        5
`define CTRL_SRC_LO     8
`define CTRL_LIMIT_EN   12
`define CTRL_MON_CH_LO  16
`endif

// File: hw/scan_seq_pkg.sv
/*
 Types for the triggered scan sequencer.
 Assumes the defines header is on the include path.
*/
`include "scan_seq_defines.svh"
package scan_seq_pkg;
	// Gray along off -> armed -> measuring -> idle
	typedef enum logic [1:0] {
		ST_OFF  = 2'b00,
		ST_ARM  = 2'b01,
		ST_MEAS = 2'b11,
		ST_IDLE = 2'b10
	} seq_state_t;

	typedef struct packed {
		logic low_one;
		logic high_one;
		logic low_two;
		logic high_two;
	} thresh_t;

	typedef struct packed {
		seq_state_t         state;
		logic               list_mode;      // 1 whole-list, 0 stepping
		logic               ext_mode;
		logic               mon_on;
		logic               imm_start;
		thresh_t            src_en;
		logic               limit_en;
		logic [`CH_W-1:0]   mon_ch;
		logic [`CH_W-1:0]   list_len;
		logic [`CNT_W-1:0]  read_cnt;
		logic [`CNT_W-1:0]  mon_cnt;
		logic [`CH_W-1:0]   ch;
		logic [`CNT_W-1:0]  done_cnt;
		logic               trig_s1;
		logic               trig_s2;
		logic               trig_s3;
		logic               meas_strobe;
		logic               blank;
		logic [31:0]        prdata;
		logic               pready;
		logic [`CNT_W-1:0]  held_reading;
		logic               hold_valid;
		logic [`CNT_W-1:0]  disp;
	} seq_regs_t;
endpackage : scan_seq_pkg

// File: tb/scan_seq_monitor.sv
/*
 Port checker for the scan sequencer.
 Assumes a bind from the bench top file.
*/
`timescale 1ns/100ps
`default_nettype none
module scan_seq_monitor
	import scan_seq_pkg::*;
(
	input wire logic             clk,
	input wire logic             rst_n,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [11:0]      paddr,
	input wire logic [31:0]      pwdata,
	input wire logic             pready,
	input wire logic             pslverr,
	input wire logic             meas_strobe,
	input wire logic [`CH_W-1:0] closed_ch,
	input wire logic             channel_closed,
	input wire logic             step_indicator,
	input wire logic             list_indicator,
	input wire logic             trig_indicator,
	input wire logic             display_blank,
	input wire logic             high_limit_indicator,
	input wire logic             low_limit_indicator
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Halt written through the register bus
	sequence halt_wr;
		psel && penable && pready && pwrite && paddr == `ADDR_CTRL && pwdata[`CTRL_HALT];
	endsequence
	sequence scan_off;
		##[1:2] !channel_closed;
	endsequence
	chk_pready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	chk_slverr_low: assert property (!pslverr) else $error("pslverr raised");
	chk_strobe_closed: assert property (meas_strobe |-> channel_closed) else $error("strobe with scan off");
	chk_strobe_single: assert property (meas_strobe |=> !meas_strobe) else $error("strobe not single");
	chk_first_chan: assert property ($rose(channel_closed) |-> closed_ch == '0) else $error("first channel wrong");
	chk_limit_pair: assert property (high_limit_indicator == low_limit_indicator) else $error("limit lamps differ");
	chk_mode_excl: assert property (!(step_indicator && list_indicator)) else $error("both modes lit");
	chk_enabled_ind: assert property (channel_closed == (step_indicator || list_indicator)) else $error("enable lamp");
	chk_halt_off: assert property (halt_wr |-> scan_off) else $error("halt ignored");
	chk_blank_entry: assert property ($rose(trig_indicator) |-> display_blank) else $error("no blank");
endmodule : scan_seq_monitor
`default_nettype wire

// File: tb/meas_engine_model.sv
/*
 Measurement engine and trigger source beside the sequencer.
 Assumes the bench pulses fire for each external trigger.
*/
`timescale 1ns/100ps
`default_nettype none
module meas_engine_model (
	input wire logic   clk,
	input wire logic   meas_strobe,
	input wire logic   fire,
	output var logic   meas_done,
	output var logic   ext_trig_in,
	output var logic [15:0] meas_reading
);
	logic [2:0] dly = '0;
	logic [2:0] hold = '0;
	initial meas_done = 1'b0;
	initial ext_trig_in = 1'b0;
	initial meas_reading = 16'h0100;
	// Answer each strobe four cycles later, new reading each time
	always @(posedge clk) begin
		meas_done <= (dly == 3'h1);
		dly <= meas_strobe ? 3'h3 : (dly != 0 ? dly - 1 : dly);
		if (dly == 3'h1) meas_reading <= meas_reading + 16'h0011;
	end
	always @(posedge clk) begin
		hold <= fire ? 3'h4 : (hold != 0 ? hold - 1 : hold);
		ext_trig_in <= fire || hold > 1;
	end
endmodule : meas_engine_model
`default_nettype wire

// File: tb/triggered_scan_sequencer_tb_top.sv
/*
 Bench for the scan sequencer: register tasks and scenario calls.
 Assumes the package, design, checker and engine model compile first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g,e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module triggered_scan_sequencer_tb_top;
	import scan_seq_pkg::*;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, fire = 0, trig_key = 0, ovr = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, ctl;
	thresh_t hit = '0;
	logic pready, pslverr, meas_strobe, meas_done, ext_trig_in, channel_closed, step_indicator, list_indicator;
	logic trig_indicator, display_blank, monitor_indicator, high_limit_indicator, low_limit_indicator;
	logic [`CH_W-1:0] closed_ch;
	logic [`CNT_W-1:0] meas_reading, display_value;
	logic [31:0] mv [4] = '{32'h1, 32'hd6d8, 32'hd6d9, 32'h2};
	logic [31:0] me [4] = '{32'h2, 32'hd6d8, 32'hd6d8, 32'h2};
	int n_errors = 0, cmp_count = 0, n_strobe = 0, k;
	always #5 clk = ~clk;
	always @(posedge clk) if (meas_strobe === 1'b1) n_strobe <= n_strobe + 1;
	scan_seq DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_key(trig_key),
		.ext_trig_in(ext_trig_in), .meas_done(meas_done), .meas_reading(meas_reading), .reading_sign_neg(1'b0),
		.over_range_indication(ovr), .thresh_hit(hit), .meas_strobe(meas_strobe), .closed_ch(closed_ch),
		.channel_closed(channel_closed), .step_indicator(step_indicator), .list_indicator(list_indicator),
		.trig_indicator(trig_indicator), .display_blank(display_blank), .monitor_indicator(monitor_indicator),
		.high_limit_indicator(high_limit_indicator), .low_limit_indicator(low_limit_indicator),
		.display_value(display_value));
	meas_engine_model ENG (.clk(clk), .meas_strobe(meas_strobe), .fire(fire), .meas_done(meas_done),
		.ext_trig_in(ext_trig_in), .meas_reading(meas_reading));
	task print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	// One APB transfer, held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk) penable <= 1;
		for (i = 0; i < 20; i++) begin @(posedge clk); if (pready === 1'b1) break; end
		rd = prdata;
		if (i == 20) begin n_errors++; print_verdict; end
		psel <= 0; penable <= 0;
		@(posedge clk);
	endtask : apb
	task ctl_w(input logic [31:0] p); apb(1, `ADDR_CTRL, ctl | p); endtask : ctl_w
	// Bounded wait for a total number of measurements
	task wait_n(input int n);
		for (int i = 0; i < 400 && n_strobe < n; i++) @(posedge clk);
		if (n_strobe < n) begin n_errors++; print_verdict; end
		repeat (8) @(posedge clk);
	endtask : wait_n
	task pulse(input logic ext); if (ext) fire <= 1; else trig_key <= 1; @(posedge clk) begin fire <= 0; trig_key <= 0; end endtask : pulse
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1;
		repeat (2) @(posedge clk);
		apb(0, `ADDR_LIST, 0); `CHK(rd, 32'h1)
		apb(0, 12'h020, 0); `CHK(rd, 32'h0)
		for (k = 0; k < 4; k++) begin apb(1, `ADDR_MONCNT, mv[k]); apb(0, `ADDR_MONCNT, 0); `CHK(rd, me[k]) end
		$display("test count range done");
		ctl = 32'h1 << `CTRL_LIMIT_EN;
		ctl_w(32'h1 << `CTRL_EXT_TOG);
		`CHK({high_limit_indicator, low_limit_indicator, trig_indicator, display_blank}, 4'hf)
		apb(1, `ADDR_LIST, 3); apb(1, `ADDR_COUNT, 4);
		ctl_w(32'h1 << `CTRL_STEP_REQ); repeat (10) @(posedge clk);
		`CHK({n_strobe[3:0], channel_closed, closed_ch}, {4'h0, 1'b1, 6'h0})
		for (k = 1; k < 5; k++) begin pulse(1); wait_n(k); `CHK(closed_ch, 6'(k % 3)) end
		apb(0, `ADDR_STATUS, 0); `CHK({rd[1:0], step_indicator, n_strobe[3:0]}, {2'b10, 1'b1, 4'h4})
		pulse(1); wait_n(5); ctl_w(32'h1 << `CTRL_HALT);
		`CHK({channel_closed, trig_indicator}, 2'b01)
		$display("test stepping done");
		apb(1, `ADDR_COUNT, 2); ctl_w(32'h1 << `CTRL_LIST_REQ); repeat (10) @(posedge clk);
		pulse(0); wait_n(8); `CHK(closed_ch, 6'h0)
		repeat (20) @(posedge clk); `CHK(n_strobe[7:0], 8'd8)
		pulse(0); wait_n(11); apb(0, `ADDR_STATUS, 0);
		`CHK({rd[1:0], list_indicator, n_strobe[7:0]}, {2'b10, 1'b1, 8'd11})
		$display("test whole list done");
		ctl_w((32'h1 << `CTRL_EXT_TOG) | (32'h1 << `CTRL_MON_TOG)); apb(1, `ADDR_COUNT, 1);
		ctl = ctl | (32'h4 << `CTRL_SRC_LO); ctl_w(0);
		hit.high_one <= 1; wait_n(14); wait_n(17);
		`CHK({monitor_indicator, list_indicator, step_indicator}, 3'b110)
		hit.high_one <= 0; repeat (40) @(posedge clk);
		`CHK(display_value, meas_reading)
		ctl = (32'h1 << `CTRL_LIMIT_EN) | (32'h8 << `CTRL_SRC_LO); ctl_w(0);
		ovr <= 1; hit.low_one <= 1; k = n_strobe; repeat (40) @(posedge clk);
		`CHK(n_strobe, k)
		ctl_w(32'h1 << `CTRL_MON_TOG);
		`CHK({monitor_indicator, high_limit_indicator}, 2'b01)
		$display("test monitor done");
		print_verdict;
	end
endmodule : triggered_scan_sequencer_tb_top
bind scan_seq scan_seq_monitor MON (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .meas_strobe(meas_strobe),
	.closed_ch(closed_ch), .channel_closed(channel_closed), .step_indicator(step_indicator),
	.list_indicator(list_indicator), .trig_indicator(trig_indicator), .display_blank(display_blank),
	.high_limit_indicator(high_limit_indicator), .low_limit_indicator(low_limit_indicator));
`default_nettype wire
